/* hw/tvc_pkg.sv */
// tvc_pkg: constants shared by the receiver system control block.
// assumes a 50 MHz system clock; level classes arrive pre-quantised.
package tvc_pkg;
	localparam int unsigned CLK_HZ = 50000000;
	localparam int unsigned PROT_TIME_MS = 1000;
	localparam int unsigned PROT_CYCLES = (CLK_HZ / 1000) * PROT_TIME_MS;
	localparam int unsigned AFT_STEP_US = 1000;
	localparam int unsigned AFT_STEP_CYCLES = (CLK_HZ / 1000000) * AFT_STEP_US;
	localparam int unsigned PULSE_LOSS_US = 40000;
	localparam int unsigned PULSE_LOSS_CYCLES =
		(CLK_HZ / 1000000) * PULSE_LOSS_US;
	localparam int unsigned FILT_LEN = 4;
	localparam int unsigned I2C_DIV = 125;
	// sound-standard option codes
	localparam logic [2:0] SND_OPT_NONE = 3'h0;
	localparam logic [2:0] SND_OPT_EAST = 3'h1;
	// tuning offset level classes
	localparam logic [2:0] TOL_LL = 3'h0;
	localparam logic [2:0] TOL_L = 3'h1;
	localparam logic [2:0] TOL_M = 3'h2;
	localparam logic [2:0] TOL_H = 3'h3;
	localparam logic [2:0] TOL_HH = 3'h4;
	// band codes
	localparam logic [1:0] BAND_VL = 2'h0;
	localparam logic [1:0] BAND_VH = 2'h1;
	localparam logic [1:0] BAND_UHF = 2'h2;
	// colour setting codes
	localparam logic [1:0] COL_AUTO = 2'h0;
	localparam logic [1:0] COL_PAL = 2'h1;
	localparam logic [1:0] COL_SECAM = 2'h2;
	localparam logic [1:0] COL_NTSC = 2'h3;
	localparam logic [7:0] TUNE_RESET = 8'h80;
	localparam logic [6:0] ADDR_TXT = 7'h11;
	localparam logic [6:0] ADDR_STEREO = 7'h12;
	localparam logic [6:0] ADDR_DSOUND = 7'h13;
	typedef enum logic [5:0] {
		PR_IDLE = 6'h01,
		PR_START = 6'h02,
		PR_BIT = 6'h04,
		PR_ACK = 6'h08,
		PR_STOP = 6'h10,
		PR_DONE = 6'h20
	} tvc_probe_t;
endpackage : tvc_pkg

/* hw/tvc_ctrl.sv */
// tvc_ctrl: system control logic of a television receiver.
// assumes inputs synchronous to clk_sys_i and pre-classified levels.
`timescale 1ns/10ps
// filter: a level must stay put FILT_LEN + 1 samples before use
module tvc_filt
	import tvc_pkg::*;
#(
	parameter int W = 1
)(
	input wire logic clk_sys_i,
	input wire logic rst_b_i,
	input wire logic [W-1:0] raw_i,
	output logic [W-1:0] stable_o
);
	logic [W-1:0] last;
	logic [2:0] cnt;
	// hold count resets on any change [RULE_21]
	always_ff @(posedge clk_sys_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			last <= '0;
			cnt <= 3'h0;
			stable_o <= '0;
		end
		else if (raw_i != last)
		begin
			last <= raw_i;
			cnt <= 3'h0;
		end
		else if (cnt == 3'(FILT_LEN - 1))
			stable_o <= last; // [RULE_21]
		else
			cnt <= cnt + 3'h1;
	end
endmodule : tvc_filt
// Behaviour
// [RULE_01] east option: two lines input, B/G high
// [RULE_02] no sound option: all four lines input
// [RULE_03] colour input inverted copy; low means mono
// [RULE_04] mono NTSC needs auto/NTSC, 60Hz, tuner
// [RULE_05] 4.43 carrier drives 4.5MHz select low
// [RULE_06] presence input low means signal present
// [RULE_07] AV without signal drives overlay blue high
// [RULE_08] I2C master, eight-bit units on SDA/SCL
// [RULE_09] probe each decoder once; ack marks available
// [RULE_10] band: VL=HL, VH=LH, UHF=HH
// [RULE_11] tuned when ident high and level middle
// [RULE_12] ident high, level above: raise tuning
// [RULE_13] ident high, level below: lower tuning
// [RULE_14] five classes: two down, middle, two up
// [RULE_15] tuning correction runs continuously
// [RULE_16] power high when on, low in standby
// [RULE_17] protection low one second forces standby
// [RULE_18] overlay needs both sync pulses present
// [RULE_19] colour control level drives decoder pin
// [RULE_20] source select high tuner, low AV
// [RULE_21] inputs held several samples before use
// [RULE_22] tuning moves one step, saturates
module tvc_ctrl
	import tvc_pkg::*;
#(
	parameter int unsigned PROT_LIMIT = PROT_CYCLES,
	parameter int unsigned STEP_LIMIT = AFT_STEP_CYCLES,
	parameter int unsigned LOSS_LIMIT = PULSE_LOSS_CYCLES
)(
	input wire logic clk_sys_i,
	input wire logic rst_b_i,
	input wire logic [2:0] snd_option_i,
	input wire logic snd_dk_sel_i,
	input wire logic colour_presence_input_i,
	input wire logic [1:0] colour_setting_i,
	input wire logic field_60hz_i,
	input wire logic ident_i,
	input wire logic signal_presence_input_i,
	input wire logic [2:0] tuning_offset_level_i,
	input wire logic tuner_or_external_source_i,
	input wire logic [1:0] band_sel_i,
	input wire logic standby_req_i,
	input wire logic wake_req_i,
	input wire logic protect_i,
	input wire logic hpulse_i,
	input wire logic vpulse_i,
	input wire logic overlay_req_i,
	input wire logic [7:0] colour_level_i,
	input wire logic sda_i,
	output logic [3:0] sound_carrier_standard_o,
	output logic [3:0] sound_carrier_standard_oe_b_o,
	output logic is_colour_o,
	output logic is_ntsc_mono_o,
	output logic [7:0] colour_ctrl_o,
	output logic no_signal_o,
	output logic overlay_blue_o,
	output logic overlay_enable_o,
	output logic source_tuner_o,
	output logic band_hi_o,
	output logic band_lo_o,
	output logic [7:0] tune_o,
	output logic tuned_o,
	output logic power_on_o,
	output logic power_fault_o,
	output logic scl_oe_b_o,
	output logic sda_oe_b_o,
	output logic [2:0] dec_avail_o,
	output logic probe_done_o
);
	logic colour_f, ident_f, sig_f, prot_f, f60_f, hp_d, vp_d;
	logic [2:0] tol_f;
	logic [31:0] prot_cnt, step_cnt, h_cnt, v_cnt;
	tvc_probe_t st;
	logic [6:0] div;
	logic [1:0] phase, dev;
	logic [3:0] bit_idx;
	logic [7:0] shreg;
	tvc_filt #(.W(1)) u_fc (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
		.raw_i(colour_presence_input_i), .stable_o(colour_f));
	tvc_filt #(.W(1)) u_fi (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
		.raw_i(ident_i), .stable_o(ident_f));
	tvc_filt #(.W(1)) u_fs (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
		.raw_i(signal_presence_input_i), .stable_o(sig_f));
	tvc_filt #(.W(1)) u_fp (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
		.raw_i(protect_i), .stable_o(prot_f));
	tvc_filt #(.W(1)) u_ff (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
		.raw_i(field_60hz_i), .stable_o(f60_f));
	tvc_filt #(.W(3)) u_ft (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
		.raw_i(tuning_offset_level_i), .stable_o(tol_f));
	// decisions from filtered levels and the unfiltered source select and colour setting
	wire mono = ~colour_f; // [RULE_03]
	wire is_tv = tuner_or_external_source_i; // [RULE_20]
	wire ntsc_mono = mono & f60_f & is_tv &
		(colour_setting_i == COL_AUTO || colour_setting_i == COL_NTSC);
	wire nosig = sig_f; // [RULE_06]
	wire go_down = ident_f & (tol_f == TOL_LL || tol_f == TOL_L); // [RULE_14]
	wire go_up = ident_f & (tol_f == TOL_H || tol_f == TOL_HH); // [RULE_14]
	wire tuned = ident_f & (tol_f == TOL_M); // [RULE_11]
	wire carrier_443 = colour_f & ~f60_f; // 4.43 assumed at 50 Hz fields
	wire east = (snd_option_i == SND_OPT_EAST);
	// east option: lines 0,2 driven, 1,3 released [RULE_01]
	wire [3:0] next_snd_oe_b = east ? 4'hA : 4'hF; // [RULE_02]
	wire [3:0] next_snd = east ? {1'b0, ~snd_dk_sel_i, 1'b0,
		~carrier_443} : 4'h0; // [RULE_01] [RULE_05]
	wire band_hi_n = (band_sel_i == BAND_VL) | (band_sel_i == BAND_UHF);
	wire band_lo_n = (band_sel_i == BAND_VH) | (band_sel_i == BAND_UHF);
	wire prot_trip = (prot_cnt == PROT_LIMIT - 1) & ~prot_f;
	wire tick = (div == 7'(I2C_DIV - 1));
	wire [6:0] cur_addr = (dev == 2'h0) ? ADDR_TXT :
		(dev == 2'h1) ? ADDR_STEREO : ADDR_DSOUND;
	// status and drive outputs
	always_ff @(posedge clk_sys_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			sound_carrier_standard_o <= 4'h0;
			sound_carrier_standard_oe_b_o <= 4'hF;
			is_colour_o <= 1'b0;
			is_ntsc_mono_o <= 1'b0;
			colour_ctrl_o <= 8'h00;
			no_signal_o <= 1'b1;
			overlay_blue_o <= 1'b0;
			source_tuner_o <= 1'b1;
			band_hi_o <= 1'b1;
			band_lo_o <= 1'b0;
			tuned_o <= 1'b0;
		end
		else
		begin
			sound_carrier_standard_oe_b_o <= next_snd_oe_b;
			sound_carrier_standard_o <= next_snd;
			is_colour_o <= colour_f;
			is_ntsc_mono_o <= ntsc_mono; // [RULE_04]
			colour_ctrl_o <= colour_level_i; // [RULE_19]
			no_signal_o <= nosig;
			overlay_blue_o <= ~is_tv & nosig; // [RULE_07]
			source_tuner_o <= is_tv; // [RULE_20]
			band_hi_o <= band_hi_n; // [RULE_10]
			band_lo_o <= band_lo_n; // [RULE_10]
			tuned_o <= tuned;
		end
	end
	// continuous fine tuning, one step per interval [RULE_15]
	always_ff @(posedge clk_sys_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			step_cnt <= 32'h0;
			tune_o <= TUNE_RESET;
		end
		else if (step_cnt != STEP_LIMIT - 1)
			step_cnt <= step_cnt + 32'h1;
		else
		begin
			step_cnt <= 32'h0;
			if (go_up && tune_o != 8'hFF)
				tune_o <= tune_o + 8'h01; // [RULE_12] [RULE_22]
			else if (go_down && tune_o != 8'h00)
				tune_o <= tune_o - 8'h01; // [RULE_13] [RULE_22]
		end
	end
	// power and protection; fault held until a wake request
	always_ff @(posedge clk_sys_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			prot_cnt <= 32'h0;
			power_on_o <= 1'b1;
			power_fault_o <= 1'b0;
		end
		else
		begin
			if (prot_f || !power_on_o)
				prot_cnt <= 32'h0; // short lows never accumulate
			else if (!prot_trip)
				prot_cnt <= prot_cnt + 32'h1;
			if (prot_trip && power_on_o)
			begin
				power_on_o <= 1'b0; // [RULE_17]
				power_fault_o <= 1'b1;
			end
			else if (standby_req_i)
				power_on_o <= 1'b0; // [RULE_16]
			else if (wake_req_i)
			begin
				power_on_o <= 1'b1; // [RULE_16]
				power_fault_o <= 1'b0;
			end
		end
	end
	// pulse watchdogs gate the overlay [RULE_18]
	always_ff @(posedge clk_sys_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			hp_d <= 1'b0;
			vp_d <= 1'b0;
			h_cnt <= 32'h0;
			v_cnt <= 32'h0;
			overlay_enable_o <= 1'b0;
		end
		else
		begin
			hp_d <= hpulse_i;
			vp_d <= vpulse_i;
			h_cnt <= (hpulse_i & ~hp_d) ? 32'h0 :
				(h_cnt == LOSS_LIMIT ? h_cnt : h_cnt + 32'h1);
			v_cnt <= (vpulse_i & ~vp_d) ? 32'h0 :
				(v_cnt == LOSS_LIMIT ? v_cnt : v_cnt + 32'h1);
			overlay_enable_o <= overlay_req_i & (h_cnt != LOSS_LIMIT) &
				(v_cnt != LOSS_LIMIT); // [RULE_18]
		end
	end
	// power-on decoder probe: start, address+W, ack, stop per device
	always_ff @(posedge clk_sys_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			st <= PR_IDLE;
			div <= 7'h0;
			phase <= 2'h0;
			dev <= 2'h0;
			bit_idx <= 4'h0;
			shreg <= 8'h00;
			scl_oe_b_o <= 1'b1;
			sda_oe_b_o <= 1'b1;
			dec_avail_o <= 3'h0;
			probe_done_o <= 1'b0;
		end
		else
		begin
			div <= tick ? 7'h0 : div + 7'h1;
			if (tick)
			begin
				phase <= phase + 2'h1;
				case (st)
					PR_IDLE:
					begin
						shreg <= {cur_addr, 1'b0};
						bit_idx <= 4'h0;
						phase <= 2'h0;
						st <= PR_START;
					end
					PR_START:
					begin
						if (phase == 2'h1)
							sda_oe_b_o <= 1'b0;
						if (phase == 2'h3)
						begin
							scl_oe_b_o <= 1'b0;
							st <= PR_BIT;
						end
					end
					PR_BIT:
					begin
						if (phase == 2'h0)
							sda_oe_b_o <= shreg[7]; // [RULE_08]
						if (phase == 2'h1)
							scl_oe_b_o <= 1'b1;
						if (phase == 2'h3)
						begin
							scl_oe_b_o <= 1'b0;
							shreg <= {shreg[6:0], 1'b0};
							bit_idx <= bit_idx + 4'h1;
							if (bit_idx == 4'h7)
								st <= PR_ACK; // [RULE_08]
						end
					end
					PR_ACK:
					begin
						if (phase == 2'h0)
							sda_oe_b_o <= 1'b1;
						if (phase == 2'h1)
							scl_oe_b_o <= 1'b1;
						if (phase == 2'h2 && !sda_i)
							dec_avail_o[dev] <= 1'b1; // [RULE_09]
						if (phase == 2'h3)
						begin
							scl_oe_b_o <= 1'b0;
							st <= PR_STOP;
						end
					end
					PR_STOP:
					begin
						if (phase == 2'h0)
							sda_oe_b_o <= 1'b0;
						if (phase == 2'h1)
							scl_oe_b_o <= 1'b1;
						if (phase == 2'h3)
						begin
							sda_oe_b_o <= 1'b1;
							dev <= dev + 2'h1;
							st <= (dev == 2'h2) ? PR_DONE : PR_IDLE; // [RULE_09]
						end
					end
					PR_DONE: probe_done_o <= 1'b1;
					default: st <= PR_IDLE;
				endcase
			end
		end
	end
endmodule : tvc_ctrl

/* dv/tvc_ctrl_properties.sv */
// tvc_ctrl_properties: port-level checks of the system control block.
// assumes it is bound into every tvc_ctrl instance.
`timescale 1ns/10ps
module tvc_ctrl_properties
	import tvc_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic rst_b_i,
	input wire logic [2:0] snd_option_i,
	input wire logic snd_dk_sel_i,
	input wire logic ident_i,
	input wire logic signal_presence_input_i,
	input wire logic [2:0] tuning_offset_level_i,
	input wire logic [1:0] band_sel_i,
	input wire logic standby_req_i,
	input wire logic protect_i,
	input wire logic overlay_req_i,
	input wire logic [3:0] sound_carrier_standard_o,
	input wire logic [3:0] sound_carrier_standard_oe_b_o,
	input wire logic no_signal_o,
	input wire logic overlay_blue_o,
	input wire logic overlay_enable_o,
	input wire logic source_tuner_o,
	input wire logic band_hi_o,
	input wire logic band_lo_o,
	input wire logic [7:0] tune_o,
	input wire logic power_on_o,
	input wire logic power_fault_o
);
	// single domain, so clock and reset are stated once
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_b_i);

	// eight steady samples always outlast the input filter
	AST_SND_NONE: assert property (
		(snd_option_i != SND_OPT_EAST) [*8] |=>
		sound_carrier_standard_oe_b_o == 4'hF) else $error("lines driven");
	AST_SND_EAST: assert property (
		(snd_option_i == SND_OPT_EAST && !snd_dk_sel_i) [*8] |=>
		sound_carrier_standard_oe_b_o == 4'hA && sound_carrier_standard_o[2])
		else $error("east lines wrong");
	AST_NO_SIG: assert property (
		signal_presence_input_i [*8] |=> no_signal_o) else $error("no signal");
	AST_BLUE: assert property (
		overlay_blue_o |-> no_signal_o && !source_tuner_o)
		else $error("blue in wrong mode");
	AST_UHF: assert property (
		(band_sel_i == BAND_UHF) [*8] |=> band_hi_o && band_lo_o)
		else $error("uhf code");
	AST_STEP: assert property (
		$changed(tune_o) |-> 8'(tune_o - $past(tune_o)) inside {8'h01, 8'hFF})
		else $error("tune jump");
	AST_HOLD: assert property (
		(ident_i && tuning_offset_level_i == TOL_M) [*8] |=> $stable(tune_o))
		else $error("tuned but moving");
	AST_PROT: assert property (
		$rose(power_fault_o) |-> !$past(protect_i, 8) ##[0:1] !power_on_o)
		else $error("fault without cause");
	AST_STBY: assert property (
		standby_req_i [*8] |=> !power_on_o) else $error("still on");
	AST_OVL: assert property (
		(!overlay_req_i) [*8] |=> !overlay_enable_o) else $error("overlay on");
	// main scenarios
	cover property ($rose(power_fault_o));
	cover property (tune_o == 8'hFF);
	cover property ($rose(overlay_enable_o));
endmodule : tvc_ctrl_properties

bind tvc_ctrl tvc_ctrl_properties tvc_ctrl_properties_i (
	.clk_sys_i(clk_sys_i),
	.rst_b_i(rst_b_i),
	.snd_option_i(snd_option_i),
	.snd_dk_sel_i(snd_dk_sel_i),
	.ident_i(ident_i),
	.signal_presence_input_i(signal_presence_input_i),
	.tuning_offset_level_i(tuning_offset_level_i),
	.band_sel_i(band_sel_i),
	.standby_req_i(standby_req_i),
	.protect_i(protect_i),
	.overlay_req_i(overlay_req_i),
	.sound_carrier_standard_o(sound_carrier_standard_o),
	.sound_carrier_standard_oe_b_o(sound_carrier_standard_oe_b_o),
	.no_signal_o(no_signal_o),
	.overlay_blue_o(overlay_blue_o),
	.overlay_enable_o(overlay_enable_o),
	.source_tuner_o(source_tuner_o),
	.band_hi_o(band_hi_o),
	.band_lo_o(band_lo_o),
	.tune_o(tune_o),
	.power_on_o(power_on_o),
	.power_fault_o(power_fault_o)
);

/* dv/tvc_dec_model.sv */
// tvc_dec_model: optional decoders answering the power-on probe.
// assumes the bench resolves both open-drain lines with pull-ups.
`timescale 1ns/10ps
module tvc_dec_model
	import tvc_pkg::*;
#(
	parameter logic [2:0] PRESENT = 3'h5
)(
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_oe_b_o
);
	logic [3:0] cnt = 4'h0;
	logic [7:0] sh = 8'h00;
	logic [7:0] starts = 8'h00;
	logic [7:0] seen = 8'h00;
	logic ack_b = 1'h1;
	logic hit;
	// start condition: data falls while the clock is high
	always @(negedge sda_i)
		if (scl_i)
			starts <= starts + 8'h01;
	// address bits taken on rising clock, msb first
	// first rising clock after a start restarts the bit count
	always @(posedge scl_i)
	begin
		sh <= {sh[6:0], sda_i};
		seen <= starts;
		cnt <= (starts != seen) ? 4'h1 : cnt + 4'h1;
	end
	// absent decoders stay silent, line falls back to pull-up
	assign hit = (sh[7:1] == ADDR_TXT && PRESENT[0]) ||
		(sh[7:1] == ADDR_STEREO && PRESENT[1]) ||
		(sh[7:1] == ADDR_DSOUND && PRESENT[2]);
	// ack held from the eighth falling clock to the ninth
	always @(negedge scl_i)
		ack_b <= !(cnt == 4'h8 && hit);
	assign sda_oe_b_o = ack_b;
endmodule : tvc_dec_model

/* dv/tvc_ctrl_test.sv */
// tvc_ctrl_test: self-checking bench for the system control block.
// assumes the decoder model and checker are compiled before it.
`timescale 1ns/10ps
module tvc_ctrl_test
	import tvc_pkg::*;
;
	logic clk_sys_i = 1'h0, rst_b_i = 1'h0, snd_dk_sel_i = 1'h0;
	logic colour_presence_input_i = 1'h1, field_60hz_i = 1'h0, ident_i = 1'h1;
	logic signal_presence_input_i = 1'h0, tuner_or_external_source_i = 1'h1;
	logic standby_req_i = 1'h0, wake_req_i = 1'h0, protect_i = 1'h1;
	logic hpulse_i = 1'h0, vpulse_i = 1'h0, overlay_req_i = 1'h0, pls = 1'h0;
	logic [2:0] snd_option_i = 3'h1, tuning_offset_level_i = TOL_M;
	logic [1:0] colour_setting_i = COL_AUTO, band_sel_i = BAND_VL;
	logic [7:0] colour_level_i = 8'h00, pc = 8'h00;
	logic [3:0] sound_carrier_standard_o, sound_carrier_standard_oe_b_o;
	logic is_colour_o, is_ntsc_mono_o, no_signal_o, overlay_blue_o;
	logic overlay_enable_o, source_tuner_o, band_hi_o, band_lo_o, tuned_o;
	logic power_on_o, power_fault_o, scl_oe_b_o, sda_oe_b_o, probe_done_o;
	logic dec_oe_b;
	logic [7:0] colour_ctrl_o, tune_o;
	logic [2:0] dec_avail_o;
	logic [7:0] obs [16];
	logic [11:0] q [$];
	logic [11:0] n;
	int i, seed = 32'hAFA7, cmp_count = 0, miscompares = 0;
	event chk;
	// pulled-up bus: any party may pull low
	wire logic sda_i = sda_oe_b_o & dec_oe_b;

	tvc_ctrl #(.PROT_LIMIT(200), .STEP_LIMIT(8), .LOSS_LIMIT(100))
	tvc_ctrl_i (
		.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
		.snd_option_i(snd_option_i), .snd_dk_sel_i(snd_dk_sel_i),
		.colour_presence_input_i(colour_presence_input_i),
		.colour_setting_i(colour_setting_i), .field_60hz_i(field_60hz_i),
		.ident_i(ident_i),
		.signal_presence_input_i(signal_presence_input_i),
		.tuning_offset_level_i(tuning_offset_level_i),
		.tuner_or_external_source_i(tuner_or_external_source_i),
		.band_sel_i(band_sel_i), .standby_req_i(standby_req_i),
		.wake_req_i(wake_req_i), .protect_i(protect_i),
		.hpulse_i(hpulse_i), .vpulse_i(vpulse_i),
		.overlay_req_i(overlay_req_i), .colour_level_i(colour_level_i),
		.sda_i(sda_i),
		.sound_carrier_standard_o(sound_carrier_standard_o),
		.sound_carrier_standard_oe_b_o(sound_carrier_standard_oe_b_o),
		.is_colour_o(is_colour_o), .is_ntsc_mono_o(is_ntsc_mono_o),
		.colour_ctrl_o(colour_ctrl_o), .no_signal_o(no_signal_o),
		.overlay_blue_o(overlay_blue_o),
		.overlay_enable_o(overlay_enable_o),
		.source_tuner_o(source_tuner_o), .band_hi_o(band_hi_o),
		.band_lo_o(band_lo_o), .tune_o(tune_o), .tuned_o(tuned_o),
		.power_on_o(power_on_o), .power_fault_o(power_fault_o),
		.scl_oe_b_o(scl_oe_b_o), .sda_oe_b_o(sda_oe_b_o),
		.dec_avail_o(dec_avail_o), .probe_done_o(probe_done_o)
	);
	tvc_dec_model #(.PRESENT(3'h5)) tvc_dec_model_i (.scl_i(scl_oe_b_o),
		.sda_i(sda_i), .sda_oe_b_o(dec_oe_b));

	always #10 clk_sys_i = ~clk_sys_i;
	// outputs gathered by index; unset sound lines masked off
	assign obs = '{8'(sound_carrier_standard_oe_b_o),
		8'(sound_carrier_standard_o & 4'h5), 8'(is_colour_o), 8'(is_ntsc_mono_o),
		colour_ctrl_o, 8'(no_signal_o), 8'(overlay_blue_o), 8'(source_tuner_o),
		8'({band_hi_o, band_lo_o}), 8'(tuned_o), 8'(power_on_o),
		8'(power_fault_o), 8'(dec_avail_o), 8'(probe_done_o),
		8'(overlay_enable_o), tune_o};
	// sync pulses, gated off to show a missing source
	always @(negedge clk_sys_i)
	begin
		pc <= pc + 8'h01;
		hpulse_i <= pls && pc[2];
		vpulse_i <= pls && pc[5];
	end

	task automatic note(input logic [3:0] k, input logic [7:0] v);
		q.push_back({k, v});
	endtask : note
	// let inputs pass the filters before the watcher looks
	task automatic hold(input int c);
		repeat (c) @(negedge clk_sys_i);
		-> chk;
		@(negedge clk_sys_i);
	endtask : hold
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			miscompares++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : cmp
	task automatic tune(input logic [2:0] c, input logic d, input logic [7:0] t,
		input logic u);
		tuning_offset_level_i = c;
		ident_i = d;
		note(4'hF, t);
		note(4'h9, 8'(u));
		hold(2200);
	endtask : tune
	task automatic stop_test;
		$display("compares %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : stop_test

	// watcher: every queued note, oldest first, against the live output
	always @(chk)
		while (q.size() > 0)
		begin
			n = q.pop_front();
			cmp(obs[n[11:8]], n[7:0]);
		end
	// hang guard, well past the expected run
	initial
	begin
		#1600000;
		miscompares++;
		stop_test;
	end

	initial
	begin
		repeat (10) @(negedge clk_sys_i);
		rst_b_i = 1'h1;
		for (i = 0; i < 40000 && probe_done_o !== 1'h1; i++)
			@(negedge clk_sys_i);
		note(4'hD, 8'h01);
		note(4'hC, 8'h05);
		note(4'hF, 8'h80);
		hold(1);
		for (i = 0; i < 8; i++)
		begin
			snd_option_i = 3'(i);
			snd_dk_sel_i = 1'($random(seed));
			note(4'h0, (i == 1) ? 8'h0A : 8'h0F);
			note(4'h1, (i == 1) ? {5'h00, !snd_dk_sel_i, 2'h0} : 8'h00);
			hold(8);
		end
		// east option with B/G so the 4.5 MHz select follows the carrier
		snd_option_i = SND_OPT_EAST;
		snd_dk_sel_i = 1'h0;
		for (i = 0; i < 32; i++)
		begin
			{tuner_or_external_source_i, field_60hz_i, colour_setting_i,
				colour_presence_input_i} = 5'(i);
			note(4'h2, 8'(i[0]));
			note(4'h1, {5'h00, 1'h1, 1'h0, !(i[0] && !i[3])});
			note(4'h3, 8'(!i[0] && i[3] && i[4] &&
				i[2:1] inside {COL_AUTO, COL_NTSC}));
			hold(8);
		end
		for (i = 0; i < 4; i++)
		begin
			{tuner_or_external_source_i, signal_presence_input_i} = 2'(i);
			note(4'h5, 8'(i[0]));
			note(4'h6, 8'(i == 1));
			note(4'h7, 8'(i[1]));
			band_sel_i = 2'(i);
			note(4'h8, 8'({!i[0], i[0] ^ i[1]}));
			colour_level_i = 8'($random(seed));
			note(4'h4, colour_level_i);
			hold(8);
		end
		// a two-cycle glitch must not reach the decision
		signal_presence_input_i = 1'h0;
		hold(8);
		signal_presence_input_i = 1'h1;
		repeat (2) @(negedge clk_sys_i);
		signal_presence_input_i = 1'h0;
		note(4'h5, 8'h00);
		hold(8);
		tune(TOL_HH, 1'h1, 8'hFF, 1'h0);
		tune(TOL_M, 1'h1, 8'hFF, 1'h1);
		tune(TOL_L, 1'h1, 8'h00, 1'h0);
		tune(TOL_H, 1'h1, 8'hFF, 1'h0);
		tune(TOL_LL, 1'h1, 8'h00, 1'h0);
		tune(TOL_HH, 1'h0, 8'h00, 1'h0);
		protect_i = 1'h0;
		repeat (150) @(negedge clk_sys_i);
		protect_i = 1'h1;
		note(4'hA, 8'h01);
		hold(8);
		protect_i = 1'h0;
		note(4'hA, 8'h00);
		note(4'hB, 8'h01);
		hold(230);
		protect_i = 1'h1;
		wake_req_i = 1'h1;
		note(4'hA, 8'h01);
		note(4'hB, 8'h00);
		hold(8);
		standby_req_i = 1'h1;
		note(4'hA, 8'h00);
		hold(8);
		standby_req_i = 1'h0;
		pls = 1'h1;
		overlay_req_i = 1'h1;
		note(4'hE, 8'h01);
		hold(150);
		pls = 1'h0;
		note(4'hE, 8'h00);
		hold(150);
		stop_test;
	end
endmodule : tvc_ctrl_test
